// File: hw/dtw_top.sv
// Dead-time, pattern and fault protection waveform extension with APB register access.
`timescale 1ns/1ps

module dtw_top (
    input  wire logic        CLK,
    input  wire logic        RST_N,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic [3:0]  WAVE_IN,
    input  wire logic [7:0]  COMPARE_OUTPUT_ENABLE,
    input  wire logic [7:0]  TIMER_PIN_VALUE,
    input  wire logic        UPDATE,
    input  wire logic [7:0]  FAULT_EVENTS,
    input  wire logic        DEBUG_BREAK,
    input  wire logic [7:0]  PORT_DIR_IN,
    output logic      [7:0]  PIN_OUT,
    output logic      [7:0]  PIN_OWNED,
    output logic             DIR_CLEAR,
    output logic      [7:0]  DIR_CLEAR_MASK,
    output logic             DIR_RESTORE,
    output logic      [7:0]  DIR_RESTORE_VALUE,
    output logic             TIMER_ERROR_SET,
    output logic             FAULT_ACTIVE
);
    logic [5:0]  ctrl_r;
    logic [7:0]  evmask_r;
    logic [4:0]  fdctrl_r;
    logic        flag_r;
    logic [7:0]  dt_low_r;
    logic [7:0]  dt_high_r;
    logic [7:0]  dt_low_buf_r;
    logic [7:0]  dt_high_buf_r;
    logic        low_bufv_r;
    logic        high_bufv_r;
    logic [7:0]  override_r;
    logic [7:0]  takeover_r;
    logic        lock_r;
    logic        fault_r;
    logic [7:0]  saved_dir_r;
    logic [3:0]  wave_prev_r;
    logic [7:0]  dead_cnt_r [4];
    logic [7:0]  pin_nxt;
    logic [7:0]  own_nxt;
    logic [31:0] rdata_nxt;
    logic [3:0]  wave_sel;
    logic [3:0]  gen_en;
    logic        wr;
    logic        rd;
    logic        fault_src;
    logic        fault_on;
    logic        restore_ok;
    logic        flag_clr;
    logic [7:0]  pair_mask;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        hit = (a == b);
    endfunction

    function automatic logic [7:0] pairs(input logic [3:0] en);
        pairs = {{2{en[3]}}, {2{en[2]}}, {2{en[1]}}, {2{en[0]}}};
    endfunction

    assign wr       = PSEL && PENABLE && PWRITE;
    assign rd       = PSEL && !PENABLE && !PWRITE;
    assign gen_en   = ctrl_r[3:0];
    assign pair_mask = pairs(gen_en);

    ////////////////////////////////////////////////////////////////////////////////
    // masked event OR
    assign fault_src = (|(FAULT_EVENTS & evmask_r)) || (DEBUG_BREAK && !fdctrl_r[dtw_pkg::FD_DBD_BIT]);
    assign fault_on  = (fdctrl_r[1:0] != dtw_pkg::ACTION_NONE) && fault_src;
    assign flag_clr  = wr && hit(PADDR, dtw_pkg::ADDR_STATUS) && PWDATA[dtw_pkg::ST_FLAG_BIT];
    assign restore_ok = !fault_src && UPDATE && (fdctrl_r[dtw_pkg::FD_MODE_BIT] || !flag_r);

    ////////////////////////////////////////////////////////////////////////////////
    // The APB slave answers every access with no wait state.
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= 32'h0000_0000;
        end
        else
        begin
            PREADY  <= PSEL && !PENABLE;
            PSLVERR <= 1'b0;
            if (rd)
                PRDATA <= rdata_nxt;
        end
    end

    always_comb
    begin
        rdata_nxt = 32'h0000_0000;
        case (PADDR)
            dtw_pkg::ADDR_CTRL:      rdata_nxt[5:0] = ctrl_r;
            dtw_pkg::ADDR_EVMASK:    rdata_nxt[7:0] = evmask_r;
            dtw_pkg::ADDR_FDCTRL:    rdata_nxt[4:0] = fdctrl_r;
            dtw_pkg::ADDR_STATUS:    rdata_nxt[2:0] = {flag_r, high_bufv_r, low_bufv_r};
            dtw_pkg::ADDR_DTBOTH,
            dtw_pkg::ADDR_DTLOW:     rdata_nxt[7:0] = dt_low_r;
            dtw_pkg::ADDR_DTHIGH:    rdata_nxt[7:0] = dt_high_r;
            dtw_pkg::ADDR_DTBOTHBUF,
            dtw_pkg::ADDR_DTLOWBUF:  rdata_nxt[7:0] = dt_low_buf_r;
            dtw_pkg::ADDR_DTHIGHBUF: rdata_nxt[7:0] = dt_high_buf_r;
            dtw_pkg::ADDR_OVERRIDE:  rdata_nxt[7:0] = override_r;
            dtw_pkg::ADDR_TAKEOVER:  rdata_nxt[7:0] = takeover_r;
            dtw_pkg::ADDR_LOCK:      rdata_nxt[0]   = lock_r;
            default:                 rdata_nxt      = 32'h0000_0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Control registers; once the lock is set only reset clears it.
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            ctrl_r     <= dtw_pkg::CTRL_RESET;
            evmask_r   <= dtw_pkg::RESET_BYTE;
            fdctrl_r   <= dtw_pkg::FDCTRL_RESET;
            override_r <= dtw_pkg::RESET_BYTE;
            takeover_r <= dtw_pkg::RESET_BYTE;
            lock_r     <= 1'b0;
        end
        else if (wr)
        begin
            if (hit(PADDR, dtw_pkg::ADDR_CTRL) && !lock_r)
                ctrl_r <= PWDATA[5:0] & dtw_pkg::CTRL_MASK;
            if (hit(PADDR, dtw_pkg::ADDR_EVMASK) && !lock_r)
                evmask_r <= PWDATA[7:0];
            if (hit(PADDR, dtw_pkg::ADDR_OVERRIDE) && !lock_r)
                override_r <= PWDATA[7:0];
            if (hit(PADDR, dtw_pkg::ADDR_FDCTRL))
                fdctrl_r <= PWDATA[4:0] & dtw_pkg::FDCTRL_MASK;
            if (hit(PADDR, dtw_pkg::ADDR_TAKEOVER) && !fault_r)
                takeover_r <= PWDATA[7:0];
            if (hit(PADDR, dtw_pkg::ADDR_LOCK) && PWDATA[0])
                lock_r <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Dead-time values and their buffers.
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            dt_low_r      <= dtw_pkg::RESET_BYTE;
            dt_high_r     <= dtw_pkg::RESET_BYTE;
            dt_low_buf_r  <= dtw_pkg::RESET_BYTE;
            dt_high_buf_r <= dtw_pkg::RESET_BYTE;
            low_bufv_r    <= 1'b0;
            high_bufv_r   <= 1'b0;
        end
        else
        begin
            if (UPDATE && low_bufv_r)
            begin
                dt_low_r   <= dt_low_buf_r;
                low_bufv_r <= 1'b0;
            end
            if (UPDATE && high_bufv_r)
            begin
                dt_high_r   <= dt_high_buf_r;
                high_bufv_r <= 1'b0;
            end
            if (wr)
            begin
                if (hit(PADDR, dtw_pkg::ADDR_DTLOW) || hit(PADDR, dtw_pkg::ADDR_DTBOTH))
                    dt_low_r <= PWDATA[7:0];
                if (hit(PADDR, dtw_pkg::ADDR_DTHIGH) || hit(PADDR, dtw_pkg::ADDR_DTBOTH))
                    dt_high_r <= PWDATA[7:0];
                if (hit(PADDR, dtw_pkg::ADDR_DTLOWBUF) || hit(PADDR, dtw_pkg::ADDR_DTBOTHBUF))
                begin
                    dt_low_buf_r <= PWDATA[7:0];
                    low_bufv_r   <= 1'b1;
                end
                if (hit(PADDR, dtw_pkg::ADDR_DTHIGHBUF) || hit(PADDR, dtw_pkg::ADDR_DTBOTHBUF))
                begin
                    dt_high_buf_r <= PWDATA[7:0];
                    high_bufv_r   <= 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Fault state, flag and port direction handling.
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            fault_r           <= 1'b0;
            flag_r            <= 1'b0;
            saved_dir_r       <= dtw_pkg::RESET_BYTE;
            DIR_CLEAR         <= 1'b0;
            DIR_CLEAR_MASK    <= dtw_pkg::RESET_BYTE;
            DIR_RESTORE       <= 1'b0;
            DIR_RESTORE_VALUE <= dtw_pkg::RESET_BYTE;
            TIMER_ERROR_SET   <= 1'b0;
            FAULT_ACTIVE      <= 1'b0;
        end
        else
        begin
            if (fault_on)
                flag_r <= 1'b1;
            else if (flag_clr)
                flag_r <= 1'b0;
            TIMER_ERROR_SET <= fault_on;
            DIR_RESTORE     <= 1'b0;
            DIR_CLEAR       <= fault_on && (fdctrl_r[1:0] == dtw_pkg::ACTION_CLEAR_DIR);
            DIR_CLEAR_MASK  <= pair_mask;
            if (fault_on && !fault_r)
            begin
                fault_r     <= 1'b1;
                saved_dir_r <= PORT_DIR_IN & pair_mask;
            end
            else if (fault_r && !fault_on && restore_ok)
            begin
                fault_r           <= 1'b0;
                DIR_RESTORE       <= 1'b1;
                DIR_RESTORE_VALUE <= saved_dir_r;
            end
            FAULT_ACTIVE <= fault_on || (fault_r && !(!fault_on && restore_ok));
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Dead-time generators.
    // common waveform select
    assign wave_sel = ctrl_r[dtw_pkg::CTRL_COMMON_BIT] ? {4{WAVE_IN[0]}} : WAVE_IN;

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            wave_prev_r <= 4'h0;
            for (int i = 0; i < 4; i++)
                dead_cnt_r[i] <= dtw_pkg::RESET_BYTE;
        end
        else
        begin
            wave_prev_r <= wave_sel;
            for (int i = 0; i < 4; i++)
            begin
                if (wave_sel[i] && !wave_prev_r[i])
                    dead_cnt_r[i] <= dt_low_r;
                else if (!wave_sel[i] && wave_prev_r[i])
                    dead_cnt_r[i] <= dt_high_r;
                else if (dead_cnt_r[i] != 8'h00)
                    dead_cnt_r[i] <= dead_cnt_r[i] - 8'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin multiplexing: timer pass-through, dead-time pairs or pattern.
    always_comb
    begin
        pin_nxt = TIMER_PIN_VALUE;
        own_nxt = COMPARE_OUTPUT_ENABLE;
        if (ctrl_r[dtw_pkg::CTRL_PATTERN_BIT])
        begin
            for (int p = 0; p < 8; p++)
            begin
                if (override_r[p])
                    pin_nxt[p] = dt_high_r[p] ? WAVE_IN[0] : dt_low_r[p];
            end
            own_nxt = override_r;
        end
        else
        begin
            for (int i = 0; i < 4; i++)
            begin
                if (gen_en[i])
                begin
                    // off while counting
                    // Both sides stay off in the cycle an edge is seen, before the counter has loaded.
                    pin_nxt[2*i]     = wave_sel[i] && wave_prev_r[i] && (dead_cnt_r[i] == 8'h00);
                    pin_nxt[2*i+1]   = !wave_sel[i] && !wave_prev_r[i] && (dead_cnt_r[i] == 8'h00);
                    own_nxt[2*i]     = override_r[2*i];
                    own_nxt[2*i+1]   = override_r[2*i+1];
                end
            end
        end
        own_nxt = own_nxt | takeover_r;
    end

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            PIN_OUT   <= dtw_pkg::RESET_BYTE;
            PIN_OWNED <= dtw_pkg::RESET_BYTE;
        end
        else
        begin
            PIN_OUT   <= pin_nxt;
            PIN_OWNED <= own_nxt;
        end
    end
endmodule

// File: hw/dtw_pkg.sv
// Package with register map, field positions and reset values of the waveform extension.
package dtw_pkg;
    localparam logic [7:0] ADDR_CTRL      = 8'h00;
    localparam logic [7:0] ADDR_EVMASK    = 8'h08;
    localparam logic [7:0] ADDR_FDCTRL    = 8'h0C;
    localparam logic [7:0] ADDR_STATUS    = 8'h10;
    localparam logic [7:0] ADDR_DTBOTH    = 8'h18;
    localparam logic [7:0] ADDR_DTBOTHBUF = 8'h1C;
    localparam logic [7:0] ADDR_DTLOW     = 8'h20;
    localparam logic [7:0] ADDR_DTHIGH    = 8'h24;
    localparam logic [7:0] ADDR_DTLOWBUF  = 8'h28;
    localparam logic [7:0] ADDR_DTHIGHBUF = 8'h2C;
    localparam logic [7:0] ADDR_OVERRIDE  = 8'h30;
    localparam logic [7:0] ADDR_TAKEOVER  = 8'h34;
    localparam logic [7:0] ADDR_LOCK      = 8'h38;
    localparam int CTRL_PATTERN_BIT  = 5;
    localparam int CTRL_COMMON_BIT   = 4;
    localparam int FD_DBD_BIT        = 4;
    localparam int FD_MODE_BIT       = 2;
    localparam int ST_FLAG_BIT       = 2;
    localparam int ST_HBUFV_BIT      = 1;
    localparam int ST_LBUFV_BIT      = 0;
    localparam logic [1:0] ACTION_NONE      = 2'h0;
    localparam logic [1:0] ACTION_CLEAR_DIR = 2'h3;
    localparam logic [7:0] RESET_BYTE     = 8'h00;
    localparam logic [5:0] CTRL_RESET     = 6'h00;
    localparam logic [4:0] FDCTRL_RESET   = 5'h00;
    localparam logic [5:0] CTRL_MASK      = 6'h3F;
    localparam logic [4:0] FDCTRL_MASK    = 5'h17;
endpackage

// File: tb/dtw_port_model.sv
// Behavioural model of the port direction register beside the extension.
`timescale 1ns/1ps
module dtw_port_model (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       dir_clear,
    input  wire logic [7:0] dir_clear_mask,
    input  wire logic       dir_restore,
    input  wire logic [7:0] dir_restore_value,
    output logic      [7:0] port_dir
);
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            port_dir <= 8'hFF;
        else if (dir_clear)
            port_dir <= port_dir & ~dir_clear_mask;
        else if (dir_restore)
            port_dir <= port_dir | dir_restore_value;
    end
endmodule

// File: tb/dtw_monitor.sv
// Checker of bus and fault timing at the ports of the waveform extension.
`timescale 1ns/1ps
module dtw_monitor (
    input wire logic       CLK,
    input wire logic       RST_N,
    input wire logic       PSEL,
    input wire logic       PENABLE,
    input wire logic       PREADY,
    input wire logic       PSLVERR,
    input wire logic       UPDATE,
    input wire logic [7:0] FAULT_EVENTS,
    input wire logic       DEBUG_BREAK,
    input wire logic       DIR_CLEAR,
    input wire logic       DIR_RESTORE,
    input wire logic       TIMER_ERROR_SET,
    input wire logic       FAULT_ACTIVE
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    sequence s_leave;
        $fell(FAULT_ACTIVE);
    endsequence
    sequence s_restore;
        DIR_RESTORE ##1 !DIR_RESTORE;
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    a_ready_access: assert property (PREADY |-> PSEL && PENABLE)
        else $error("ready outside access phase");
    a_ready_pulse: assert property (PREADY |=> !PREADY)
        else $error("ready longer than one cycle");
    a_no_slverr: assert property (!PSLVERR)
        else $error("unexpected slave error");
    a_fault_cause: assert property ($rose(FAULT_ACTIVE) |-> $past(|FAULT_EVENTS || DEBUG_BREAK))
        else $error("fault without event or break");
    a_clear_acts: assert property (DIR_CLEAR |-> TIMER_ERROR_SET && FAULT_ACTIVE)
        else $error("direction clear outside fault");
    a_rise_error: assert property ($rose(FAULT_ACTIVE) |-> TIMER_ERROR_SET)
        else $error("fault without timer error");
    a_leave_update: assert property (s_leave |-> $past(UPDATE))
        else $error("fault left without update");
    a_leave_restore: assert property (s_leave |-> s_restore)
        else $error("no single restore pulse");
endmodule

bind dtw_top dtw_monitor i_mon (
    .CLK(CLK),
    .RST_N(RST_N),
    .PSEL(PSEL),
    .PENABLE(PENABLE),
    .PREADY(PREADY),
    .PSLVERR(PSLVERR),
    .UPDATE(UPDATE),
    .FAULT_EVENTS(FAULT_EVENTS),
    .DEBUG_BREAK(DEBUG_BREAK),
    .DIR_CLEAR(DIR_CLEAR),
    .DIR_RESTORE(DIR_RESTORE),
    .TIMER_ERROR_SET(TIMER_ERROR_SET),
    .FAULT_ACTIVE(FAULT_ACTIVE)
);

// File: tb/dead_time_fault_waveform_ext_tb.sv
// Self-checking bench for the waveform extension.
`timescale 1ns/1ps
module dead_time_fault_waveform_ext_tb;
    logic        clk = 1'h0;
    logic        rst_n = 1'h0;
    logic        psel = 1'h0;
    logic        penable = 1'h0;
    logic        pwrite = 1'h0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic [3:0]  wave = 4'h0;
    logic        upd = 1'h0;
    logic [7:0]  events = 8'h00;
    logic [7:0]  cce = 8'h5A;
    logic        brk = 1'h0;
    logic [7:0]  pin_out;
    logic [7:0]  pin_owned;
    logic        dclr;
    logic [7:0]  dmask;
    logic        drst;
    logic [7:0]  dval;
    logic        tes;
    logic        fact;
    logic [7:0]  port_dir;
    logic [31:0] rd;
    int          n_fail = 0;
    int          check_count = 0;
    int          n1;
    int          n2;

    always #2 clk = ~clk;

    dtw_top i_dut (.CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(),
        .WAVE_IN(wave), .COMPARE_OUTPUT_ENABLE(cce), .TIMER_PIN_VALUE(8'hA5), .UPDATE(upd),
        .FAULT_EVENTS(events), .DEBUG_BREAK(brk), .PORT_DIR_IN(port_dir), .PIN_OUT(pin_out),
        .PIN_OWNED(pin_owned), .DIR_CLEAR(dclr), .DIR_CLEAR_MASK(dmask), .DIR_RESTORE(drst),
        .DIR_RESTORE_VALUE(dval), .TIMER_ERROR_SET(tes), .FAULT_ACTIVE(fact));

    dtw_port_model i_port (.clk(clk), .rst_n(rst_n), .dir_clear(dclr), .dir_clear_mask(dmask),
        .dir_restore(drst), .dir_restore_value(dval), .port_dir(port_dir));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'h1);
        rd = prdata;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'h0, a, 32'h0);
        cmp(rd, exp);
    endtask

    task automatic pulse;
        @(posedge clk);
        upd <= 1'h1;
        @(posedge clk);
        upd <= 1'h0;
    endtask

    // Counts cycles until a pin turns on; low and high side of pair A never both on.
    task automatic gap(input int b, output int n);
        n = 0;
        while (pin_out[b] !== 1'h1 && n < 40)
        begin
            @(posedge clk);
            n++;
            cmp(pin_out[1:0] == 2'h3, 32'h0);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        chk(dtw_pkg::ADDR_CTRL, 32'h0);
        chk(8'h3C, 32'h0);
        apb(1'h1, dtw_pkg::ADDR_CTRL, 32'hFF);
        chk(dtw_pkg::ADDR_CTRL, 32'h3F);
    endtask

    task automatic t_dead;
        apb(1'h1, dtw_pkg::ADDR_DTBOTH, 32'h02);
        apb(1'h1, dtw_pkg::ADDR_DTLOWBUF, 32'h09);
        apb(1'h1, dtw_pkg::ADDR_OVERRIDE, 32'hFF);
        apb(1'h1, dtw_pkg::ADDR_CTRL, 32'h01);
        tick(4);
        cmp(pin_owned[1:0], 32'h3);
        cmp(pin_owned, 32'h5B);
        cmp(pin_out[7:2], 32'h29);
        apb(1'h1, dtw_pkg::ADDR_TAKEOVER, 32'hFF);
        wave[0] <= 1'h1;
        gap(0, n1);
        cmp(n1 >= 3 && n1 <= 6, 32'h1);
        wave[0] <= 1'h0;
        gap(1, n2);
        cmp(n2 >= 3 && n2 <= 6, 32'h1);
        pulse();
        wave[0] <= 1'h1;
        gap(0, n2);
        cmp(n2 - n1, 32'h7);
    endtask

    task automatic t_common;
        apb(1'h1, dtw_pkg::ADDR_CTRL, 32'h13);
        @(posedge clk);
        wave[0] <= 1'h0;
        tick(12);
        wave[0] <= 1'h1;
        gap(2, n2);
        cmp(n2 - n1, 32'h7);
    endtask

    task automatic t_pattern;
        apb(1'h1, dtw_pkg::ADDR_DTLOW, 32'h5A);
        apb(1'h1, dtw_pkg::ADDR_DTHIGH, 32'h0F);
        apb(1'h1, dtw_pkg::ADDR_CTRL, 32'h20);
        pulse();
        tick(3);
        cmp(pin_out, 32'h5F);
        wave[0] <= 1'h0;
        tick(3);
        cmp(pin_out, 32'h50);
    endtask

    task automatic t_fault_cycle;
        apb(1'h1, dtw_pkg::ADDR_CTRL, 32'h03);
        apb(1'h1, dtw_pkg::ADDR_EVMASK, 32'h04);
        apb(1'h1, dtw_pkg::ADDR_FDCTRL, 32'h07);
        events <= 8'hFB;
        tick(3);
        cmp(fact, 32'h0);
        events <= 8'h04;
        tick(2);
        cmp({fact, dclr, tes, dmask}, 32'h70F);
        tick(1);
        cmp(port_dir, 32'hF0);
        apb(1'h0, dtw_pkg::ADDR_STATUS, 32'h0);
        cmp(rd[2], 32'h1);
        apb(1'h1, dtw_pkg::ADDR_TAKEOVER, 32'h00);
        chk(dtw_pkg::ADDR_TAKEOVER, 32'hFF);
        events <= 8'h00;
        tick(4);
        cmp(fact, 32'h1);
        pulse();
        tick(2);
        cmp({fact, port_dir}, 32'h0FF);
    endtask

    task automatic t_fault_latched;
        apb(1'h1, dtw_pkg::ADDR_STATUS, 32'h04);
        apb(1'h1, dtw_pkg::ADDR_FDCTRL, 32'h03);
        events <= 8'h04;
        tick(1);
        events <= 8'h00;
        pulse();
        tick(2);
        cmp(fact, 32'h1);
        apb(1'h1, dtw_pkg::ADDR_STATUS, 32'h00);
        apb(1'h0, dtw_pkg::ADDR_STATUS, 32'h0);
        cmp(rd[2], 32'h1);
        apb(1'h1, dtw_pkg::ADDR_STATUS, 32'h04);
        apb(1'h0, dtw_pkg::ADDR_STATUS, 32'h0);
        cmp(rd[2], 32'h0);
        pulse();
        tick(2);
        cmp(fact, 32'h0);
    endtask

    task automatic t_debug;
        apb(1'h1, dtw_pkg::ADDR_FDCTRL, 32'h17);
        brk <= 1'h1;
        tick(3);
        cmp(fact, 32'h0);
        apb(1'h1, dtw_pkg::ADDR_FDCTRL, 32'h07);
        tick(2);
        cmp(fact, 32'h1);
        brk <= 1'h0;
        pulse();
        tick(2);
        cmp(fact, 32'h0);
        apb(1'h1, dtw_pkg::ADDR_FDCTRL, 32'h04);
        events <= 8'h04;
        tick(3);
        cmp({fact, dclr}, 32'h0);
        events <= 8'h00;
    endtask

    task automatic t_lock;
        apb(1'h1, dtw_pkg::ADDR_LOCK, 32'h01);
        apb(1'h1, dtw_pkg::ADDR_CTRL, 32'h00);
        apb(1'h1, dtw_pkg::ADDR_EVMASK, 32'hFF);
        apb(1'h1, dtw_pkg::ADDR_OVERRIDE, 32'h00);
        chk(dtw_pkg::ADDR_CTRL, 32'h03);
        chk(dtw_pkg::ADDR_EVMASK, 32'h04);
        chk(dtw_pkg::ADDR_OVERRIDE, 32'hFF);
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial
    begin
        tick(8);
        rst_n <= 1'h1;
        t_regs();
        t_dead();
        t_common();
        t_pattern();
        t_fault_cycle();
        t_fault_latched();
        t_debug();
        t_lock();
        print_verdict();
    end

    initial
    begin
        #40000;
        n_fail++;
        print_verdict();
    end
endmodule
